// *** logic/chan_sync_ctrl.sv ***
/*
  Three channel dividers with coarse phase offset, output synchronisation,
  output polarity and power-down selection, and the chip reset modes.
  Assumes a register port fed by the serial control port logic, and clock
  enables div_tick and osc_div_tick marking divider input and oscillator
  divider input edges on clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
`include "chan_sync_defs.svh"

module chan_sync_ctrl (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic reset_pin_n,
  input wire logic sync_pin_n,
  input wire logic powerdown_pin_n,
  input wire logic cal_active,
  input wire logic div_tick,
  input wire logic div_clk_lvl,
  input wire logic osc_div_tick,
  input wire logic osc_div_used,
  input wire chan_sync_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output chan_sync_pkg::pair_out_t [2:0] pair_out,
  output logic sync_busy
);
  import chan_sync_pkg::*;

  // applied offset code to delay, in divider input cycles
  function automatic logic [5:0] offset_delay(input phase_t ph,
                                              input cyc_t cy);
    logic [5:0] d;
    d = {2'b00, ph.phase_offset_field}; // RQ3
    if (ph.start_level_bit) begin
      d = d + {2'b00, cy.low_cycles} + 6'h01; // RQ5
    end
    return d; // RQ4
  endfunction

  // level while the offset counts down: high once nothing is left, and for
  // a start-level offset high until only the low phase plus one remains
  function automatic logic lead_level(input phase_t ph, input cyc_t cy,
                                      input logic [5:0] left);
    logic hi;
    hi = `PHASE_HIGH_CODE;
    if (left != 6'h00) begin
      hi = ph.start_level_bit && left > {2'b00, cy.low_cycles} + 6'h01;
    end
    return hi;
  endfunction

  // maps an address to its channel, 3 for none
  function automatic int chan_of(input logic [9:0] a);
    int c;
    c = 3;
    if (a == `ADDR_CYC0 || a == `ADDR_PHASE0 || a == `ADDR_CHOPT0) begin
      c = 0;
    end
    if (a == `ADDR_CYC1 || a == `ADDR_PHASE1 || a == `ADDR_CHOPT1) begin
      c = 1;
    end
    if (a == `ADDR_CYC2 || a == `ADDR_PHASE2 || a == `ADDR_CHOPT2) begin
      c = 2;
    end
    return c;
  endfunction

  logic [2:0] pin_meta_r;
  logic [2:0] pin_sync_r;
  logic reset_pin_s;
  logic sync_pin_s;
  logic pd_pin_s;

  logic [7:0] port_cfg_r;
  cyc_t cyc_s_r [3];
  phase_t phase_s_r [3];
  chopt_t chopt_s_r [3];
  cyc_t cyc_a_r [3];
  phase_t phase_a_r [3];
  chopt_t chopt_a_r [3];
  logic [7:0] dist_s_r;
  logic [7:0] dist_a_r;
  logic soft_reset;
  logic update_hit;

  sync_state_t sync_state_r;
  logic [3:0] sync_cnt_r;
  logic sync_req;
  logic pin_req;
  logic soft_req;
  logic chip_req;
  logic hold;
  logic start_pulse;
  logic extra_tick;

  logic [3:0] div_cnt_r [3];
  logic [5:0] dly_r [3];
  logic [5:0] off_dly [3];
  logic [2:0] lvl_r;
  logic byp_lvl_r;
  logic [7:0] rd_nxt;

  // two flip-flops on every pin; only the second stage is read
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pin_meta_r <= 3'h7;
      pin_sync_r <= 3'h7;
    end else begin
      pin_meta_r <= {powerdown_pin_n, sync_pin_n, reset_pin_n};
      pin_sync_r <= pin_meta_r; // RQ13
    end
  end

  assign reset_pin_s = pin_sync_r[0];
  assign sync_pin_s = pin_sync_r[1];
  assign pd_pin_s = pin_sync_r[2];

  assign soft_reset = port_cfg_r[`BIT_SOFT_RESET] |
                      port_cfg_r[`BIT_SOFT_RESET_MIRROR]; // RQ22
  assign update_hit = reg_req.wr && reg_req.addr == `ADDR_UPDATE &&
                      reg_req.wdata[`BIT_UPDATE];

  // port config: written directly, no update strobe needed
  always_ff @(posedge clk_sys or negedge reset_pin_n) begin
    if (!reset_pin_n) begin
      port_cfg_r <= `RST_PORT_CFG; // RQ21
    end else if (reset) begin
      port_cfg_r <= `RST_PORT_CFG; // RQ19
    end else if (reg_req.wr && reg_req.addr == `ADDR_PORT_CFG) begin
      port_cfg_r <= reg_req.wdata; // RQ22
    end
  end

  // staged and applied copies; soft reset pins both at defaults while set
  always_ff @(posedge clk_sys or negedge reset_pin_n) begin
    if (!reset_pin_n) begin
      for (int c = 0; c < 3; c++) begin
        cyc_s_r[c] <= `RST_CYC; // RQ21
        phase_s_r[c] <= `RST_PHASE;
        chopt_s_r[c] <= `RST_CHOPT;
        cyc_a_r[c] <= `RST_CYC;
        phase_a_r[c] <= `RST_PHASE;
        chopt_a_r[c] <= `RST_CHOPT;
      end
      dist_s_r <= `RST_DIST_SYNC;
      dist_a_r <= `RST_DIST_SYNC;
    end else if (reset || soft_reset) begin
      for (int c = 0; c < 3; c++) begin
        cyc_s_r[c] <= `RST_CYC; // RQ19
        phase_s_r[c] <= `RST_PHASE;
        chopt_s_r[c] <= `RST_CHOPT;
        cyc_a_r[c] <= `RST_CYC;
        phase_a_r[c] <= `RST_PHASE;
        chopt_a_r[c] <= `RST_CHOPT;
      end
      dist_s_r <= `RST_DIST_SYNC;
      dist_a_r <= `RST_DIST_SYNC;
    end else begin
      if (reg_req.wr && chan_of(reg_req.addr) < 3) begin
        case (reg_req.addr)
          `ADDR_CYC0, `ADDR_CYC1, `ADDR_CYC2: begin
            cyc_s_r[chan_of(reg_req.addr)] <= reg_req.wdata;
          end
          `ADDR_PHASE0, `ADDR_PHASE1, `ADDR_PHASE2: begin
            phase_s_r[chan_of(reg_req.addr)] <= reg_req.wdata; // RQ2
          end
          default: begin
            chopt_s_r[chan_of(reg_req.addr)] <= reg_req.wdata;
          end
        endcase
      end
      if (reg_req.wr && reg_req.addr == `ADDR_DIST_SYNC) begin
        dist_s_r <= reg_req.wdata;
      end
      // soft sync set and clear both wait for this strobe
      if (update_hit) begin
        for (int c = 0; c < 3; c++) begin
          cyc_a_r[c] <= cyc_s_r[c];
          phase_a_r[c] <= phase_s_r[c];
          chopt_a_r[c] <= chopt_s_r[c];
        end
        dist_a_r <= dist_s_r; // RQ14
      end
    end
  end

  // any request source holds the sync; all clear releases it
  // sources are gathered apart so pin, register and chip causes stay visible
  assign pin_req = ~sync_pin_s; // RQ8
  assign soft_req = dist_a_r[`BIT_SOFT_SYNC] | // RQ24
                    dist_a_r[`BIT_DIST_PD] | soft_reset; // RQ9
  assign chip_req = ~reset_pin_s | ~pd_pin_s | // RQ10
                    cal_active; // RQ11
  assign sync_req = pin_req | soft_req | chip_req;
  assign extra_tick = osc_div_used ? osc_div_tick : div_tick;
  assign hold = sync_state_r != SY_IDLE;
  assign start_pulse = sync_state_r == SY_EXTRA && !sync_req && extra_tick;
  assign sync_busy = hold;

  // a request in any counting state restarts the hold, so a late source
  // can never cut a partial sequence short
  // reset enters hold so power-on and reset release both sync the outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync_state_r <= SY_HOLD; // RQ20
      sync_cnt_r <= 4'h0;
    end else begin
      case (sync_state_r)
        SY_IDLE: begin
          if (sync_req) begin
            sync_state_r <= SY_HOLD;
          end
        end
        SY_HOLD: begin
          sync_cnt_r <= 4'h0;
          if (!sync_req) begin
            sync_state_r <= SY_COUNT;
          end
        end
        SY_COUNT: begin
          if (sync_req) begin
            sync_state_r <= SY_HOLD;
          end else if (div_tick) begin
            sync_cnt_r <= sync_cnt_r + 4'h1;
            if (sync_cnt_r == `SYNC_COUNT_TICKS) begin
              sync_state_r <= SY_EXTRA; // RQ12
            end
          end
        end
        SY_EXTRA: begin
          if (sync_req) begin
            sync_state_r <= SY_HOLD;
          end else if (extra_tick) begin
            sync_state_r <= SY_IDLE; // RQ12
          end
        end
        default: begin
          sync_state_r <= SY_HOLD;
        end
      endcase
    end
  end

  // one offset per channel; applied values only, so new offsets wait for sync
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      off_dly[c] = offset_delay(phase_a_r[c], cyc_a_r[c]); // RQ6
    end
  end

  // divider state; excluded channels ignore hold and start entirely
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int c = 0; c < 3; c++) begin
        div_cnt_r[c] <= 4'h0;
        dly_r[c] <= 6'h00;
      end
      lvl_r <= 3'h0;
    end else begin
      for (int c = 0; c < 3; c++) begin
        if (hold && !chopt_a_r[c].exclude && !start_pulse) begin // RQ17
          lvl_r[c] <= phase_a_r[c].start_level_bit; // RQ15
          dly_r[c] <= 6'h00; // RQ7
          div_cnt_r[c] <= 4'h0;
        end else if (start_pulse && !chopt_a_r[c].exclude) begin
          dly_r[c] <= off_dly[c]; // RQ7
          div_cnt_r[c] <= 4'h0;
          lvl_r[c] <= lead_level(phase_a_r[c], cyc_a_r[c],
                                 off_dly[c]); // RQ15
        end else if (div_tick) begin
          if (dly_r[c] != 6'h00) begin
            dly_r[c] <= dly_r[c] - 6'h01; // RQ1
            lvl_r[c] <= lead_level(phase_a_r[c], cyc_a_r[c],
                                   dly_r[c] - 6'h01);
          end else if (lvl_r[c]) begin
            if (div_cnt_r[c] == cyc_a_r[c].high_cycles) begin
              lvl_r[c] <= 1'b0; // RQ23
              div_cnt_r[c] <= 4'h0;
            end else begin
              div_cnt_r[c] <= div_cnt_r[c] + 4'h1;
            end
          end else begin
            if (div_cnt_r[c] == cyc_a_r[c].low_cycles) begin
              lvl_r[c] <= 1'b1; // RQ23
              div_cnt_r[c] <= 4'h0;
            end else begin
              div_cnt_r[c] <= div_cnt_r[c] + 4'h1;
            end
          end
        end
      end
    end
  end

  // limitation: bypass skips the offset, only the hold is honoured
  // bypass follows the input clock level one cycle late
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      byp_lvl_r <= 1'b0;
    end else begin
      byp_lvl_r <= div_clk_lvl;
    end
  end

  // both outputs of a pair take the same divider level; the pin power-down
  // always leaves outputs in the protected state
  // distribution off keeps the mode bits; safe only where the mode asks it
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pair_out <= '0;
    end else begin
      for (int c = 0; c < 3; c++) begin
        logic base;
        logic off_all;
        base = (phase_a_r[c].bypass && !(hold && !chopt_a_r[c].exclude)) ?
               byp_lvl_r : lvl_r[c]; // RQ23
        off_all = dist_a_r[`BIT_DIST_PD] | ~pd_pin_s;
        pair_out[c].out_a <= base ^ chopt_a_r[c].invert_a; // RQ16
        pair_out[c].out_b <= base ^ chopt_a_r[c].invert_b; // RQ18
        pair_out[c].on_a <= !off_all && chopt_a_r[c].pd_a == PD_NORMAL;
        pair_out[c].on_b <= !off_all && chopt_a_r[c].pd_b == PD_NORMAL;
        pair_out[c].safe_a <= ~pd_pin_s ||
          ((off_all || chopt_a_r[c].pd_a != PD_NORMAL) &&
           chopt_a_r[c].pd_a == PD_SAFE); // RQ18
        pair_out[c].safe_b <= ~pd_pin_s ||
          ((off_all || chopt_a_r[c].pd_b != PD_NORMAL) &&
           chopt_a_r[c].pd_b == PD_SAFE);
      end
    end
  end

  // reads return staged values; unmapped and update read as zero
  // status bit 3 mirrors sync_busy so software can poll for completion
  always_comb begin
    rd_nxt = 8'h00;
    case (reg_req.addr)
      `ADDR_PORT_CFG: rd_nxt = port_cfg_r;
      `ADDR_CYC0: rd_nxt = cyc_s_r[0];
      `ADDR_CYC1: rd_nxt = cyc_s_r[1];
      `ADDR_CYC2: rd_nxt = cyc_s_r[2];
      `ADDR_PHASE0: rd_nxt = phase_s_r[0];
      `ADDR_PHASE1: rd_nxt = phase_s_r[1];
      `ADDR_PHASE2: rd_nxt = phase_s_r[2];
      `ADDR_CHOPT0: rd_nxt = chopt_s_r[0];
      `ADDR_CHOPT1: rd_nxt = chopt_s_r[1];
      `ADDR_CHOPT2: rd_nxt = chopt_s_r[2];
      `ADDR_STATUS: rd_nxt = {4'h0, hold, lvl_r};
      `ADDR_DIST_SYNC: rd_nxt = dist_s_r;
      default: rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      reg_rdata <= rd_nxt;
    end
  end
endmodule
`default_nettype wire

// *** common/chan_sync_defs.svh ***
/*
  Offsets, field positions, reset values and timing counts for the channel
  divider, output synchronisation and reset controller.
  Assumes inclusion by bare name from the package and the design module.
*/
// What this block does
// RQ1 - each divider delays its output rising edge by whole divider-input edges
// RQ2 - offset comes from a four-bit offset field and one start-level bit
// RQ3 - offset code is sixteen times start-level plus the offset field
// RQ4 - code up to 15 delays by the code in input periods
// RQ5 - code 16 or more delays by code minus 16 plus low count plus one
// RQ6 - new offsets only act after a synchronisation; software must trigger one
// RQ7 - sync holds non-excluded outputs static, then all resume on one edge
// RQ8 - low pulse on the sync pin starts a sync, its release ends it
// RQ9 - setting then clearing soft sync, soft reset or distribution off syncs
// RQ10 - reset pin or power-down pin low then released also syncs outputs
// RQ11 - oscillator calibration raises an internal sync request until it ends
// RQ12 - clocking resumes 14 to 15 input cycles after release, plus one cycle
// RQ13 - sync pin is asynchronous; uncertainty stays within one input cycle
// RQ14 - soft sync set and clear each act only after an update-all write
// RQ15 - start-level and offset set the held level and resume phase
// RQ16 - both outputs of a pair follow their shared divider's sync
// RQ17 - excluded channels keep clocking through sync and are not aligned
// RQ18 - each output has selectable polarity and power-down mode, one protected
// RQ19 - every reset mode restores all registers to defaults, active at once
// RQ20 - power-on loads defaults then performs a synchronisation
// RQ21 - reset pin low restores defaults without waiting for a clock edge
// RQ22 - soft reset bits 2 and 5 set then cleared by software, no update
// RQ23 - divider gives M+1 low and N+1 high cycles, bypass divides by one
// RQ24 - applied soft sync keeps outputs static until its clear is applied
`ifndef CHAN_SYNC_DEFS_SVH
`define CHAN_SYNC_DEFS_SVH

`define ADDR_PORT_CFG 10'h000
`define ADDR_CYC0 10'h190
`define ADDR_PHASE0 10'h191
`define ADDR_CYC1 10'h193
`define ADDR_PHASE1 10'h194
`define ADDR_CYC2 10'h196
`define ADDR_PHASE2 10'h197
`define ADDR_CHOPT0 10'h1A0
`define ADDR_CHOPT1 10'h1A1
`define ADDR_CHOPT2 10'h1A2
`define ADDR_STATUS 10'h1A3
`define ADDR_DIST_SYNC 10'h230
`define ADDR_UPDATE 10'h232

`define BIT_SOFT_RESET 2
`define BIT_SOFT_RESET_MIRROR 5
`define BIT_UPDATE 0
`define BIT_SOFT_SYNC 0
`define BIT_DIST_PD 1

`define RST_PORT_CFG 8'h00
`define RST_CYC 8'h00
`define RST_PHASE 8'h00
`define RST_CHOPT 8'h00
`define RST_DIST_SYNC 8'h00

`define SYNC_COUNT_TICKS 4'hD
`define PHASE_HIGH_CODE 1'b1

`endif

// *** common/chan_sync_pkg.sv ***
/*
  Types for the channel divider and synchronisation controller.
  Assumes the constants header sits beside it on the include path.
*/
package chan_sync_pkg;
  `include "chan_sync_defs.svh"

  typedef enum logic [1:0] {
    PD_NORMAL,
    PD_PARTIAL,
    PD_SAFE,
    PD_TOTAL
  } pd_mode_t;

  typedef struct packed {
    logic [3:0] low_cycles;
    logic [3:0] high_cycles;
  } cyc_t;

  typedef struct packed {
    logic bypass;
    logic [1:0] unused;
    logic start_level_bit;
    logic [3:0] phase_offset_field;
  } phase_t;

  typedef struct packed {
    logic unused;
    pd_mode_t pd_b;
    pd_mode_t pd_a;
    logic invert_b;
    logic invert_a;
    logic exclude;
  } chopt_t;

  typedef struct packed {
    logic out_a;
    logic out_b;
    logic on_a;
    logic on_b;
    logic safe_a;
    logic safe_b;
  } pair_out_t;

  typedef struct packed {
    logic [9:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    SY_IDLE,
    SY_HOLD,
    SY_COUNT,
    SY_EXTRA
  } sync_state_t;
endpackage

// *** bench/chan_sync_sva.sv ***
/*
  Port assertions for the channel sync controller.
  Assumes a bind from the bench top and one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module chan_sync_sva (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic reset_pin_n,
  input wire logic sync_pin_n,
  input wire logic powerdown_pin_n,
  input wire logic cal_active,
  input wire logic div_tick,
  input wire logic div_clk_lvl,
  input wire logic osc_div_tick,
  input wire logic osc_div_used,
  input wire chan_sync_pkg::reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire chan_sync_pkg::pair_out_t [2:0] pair_out,
  input wire logic sync_busy
);
  import chan_sync_pkg::*;
  logic [4:0] ticks_r;
  logic restart;
  logic all_safe;
  // counted from the raw pin release, so the lag of the pin flops only adds
  assign restart = !sync_pin_n || !reset_pin_n || !powerdown_pin_n ||
    cal_active || (reg_req.wr && (reg_req.addr == 10'h232 ||
    reg_req.addr == 10'h000));
  assign all_safe = pair_out[0].safe_a && pair_out[0].safe_b &&
    pair_out[1].safe_a && pair_out[1].safe_b &&
    pair_out[2].safe_a && pair_out[2].safe_b;
  always_ff @(posedge clk_sys) begin
    if (reset || restart) ticks_r <= 5'h00;
    else if (div_tick && ticks_r != 5'h1F) ticks_r <= ticks_r + 5'h01;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_min_sync_ticks: assert property ($fell(sync_busy) |-> ticks_r >= 5'h0E)
    else $error("sync ended too early");
  a_release_holds: assert property ($rose(sync_pin_n) |-> sync_busy [*8])
    else $error("sync ended right after pin release");
  a_sync_pin_holds: assert property (!sync_pin_n [*4] |-> sync_busy)
    else $error("sync pin low without sync");
  a_pd_pin_sync: assert property (!powerdown_pin_n [*4] |-> sync_busy)
    else $error("power-down pin low without sync");
  a_reset_pin_sync: assert property (!reset_pin_n [*4] |-> sync_busy)
    else $error("reset pin low without sync");
  a_cal_starts_sync: assert property (cal_active |-> ##[1:3] sync_busy)
    else $error("calibration without sync");
  a_pd_pin_safe: assert property (!powerdown_pin_n [*4] |=> all_safe)
    else $error("power-down pin without safe outputs");
  a_reset_defaults: assert property ($fell(reset) |-> sync_busy && pair_out == '0)
    else $error("reset release without default sync");
  c_sync_done: cover property ($fell(sync_busy));
  c_safe: cover property (all_safe);
  c_cal: cover property (cal_active ##1 sync_busy);
endmodule
`default_nettype wire

// *** bench/divider_clock_source.sv ***
/*
  Divider input clock source feeding the channel dividers.
  Assumes one tick every TICK_PERIOD system clocks, oscillator divider unused.
*/
`timescale 1ns/10ps
`default_nettype none
module divider_clock_source #(
  parameter int TICK_PERIOD = 4
) (
  input wire logic clk_sys,
  input wire logic reset,
  output logic div_tick,
  output logic div_clk_lvl,
  output logic osc_div_tick
);
  logic [7:0] count_r;
  // restarts on reset so tick spacing is fixed from the first edge
  always_ff @(posedge clk_sys) begin
    if (reset || count_r == 8'(TICK_PERIOD - 1)) count_r <= 8'h00;
    else count_r <= count_r + 8'h01;
  end
  assign div_tick = (count_r == 8'h00);
  assign div_clk_lvl = (count_r < 8'(TICK_PERIOD / 2));
  assign osc_div_tick = div_tick;
endmodule
`default_nettype wire

// *** bench/tb.sv ***
/*
  Self-checking bench for the channel sync controller.
  Assumes the clock source model and the checker file compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import chan_sync_pkg::*;
  logic clk_sys, reset, reset_pin_n, sync_pin_n, powerdown_pin_n, cal_active;
  logic div_tick, div_clk_lvl, osc_div_tick, sync_busy;
  reg_req_t reg_req;
  logic [7:0] reg_rdata;
  pair_out_t [2:0] pair_out;
  int failures, compares, cycles;
  chan_sync_ctrl chan_sync_ctrl_i (.clk_sys(clk_sys), .reset(reset),
    .reset_pin_n(reset_pin_n), .sync_pin_n(sync_pin_n),
    .powerdown_pin_n(powerdown_pin_n), .cal_active(cal_active),
    .div_tick(div_tick), .div_clk_lvl(div_clk_lvl),
    .osc_div_tick(osc_div_tick), .osc_div_used(1'b0), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .pair_out(pair_out), .sync_busy(sync_busy));
  divider_clock_source #(.TICK_PERIOD(4)) divider_clock_source_i (
    .clk_sys(clk_sys), .reset(reset), .div_tick(div_tick),
    .div_clk_lvl(div_clk_lvl), .osc_div_tick(osc_div_tick));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      wrap_up();
    end
  end
  task automatic chk_byte(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // strobe for one edge, then a quiet edge so the next request never clashes
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    cyc(1);
    reg_req.wr <= 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] exp,
    input string what);
    reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    cyc(1);
    reg_req.rd <= 1'b0;
    cyc(1);
    chk_byte(what, exp, reg_rdata);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (sync_busy !== 1'b0 && n < 400) begin
      cyc(1);
      n++;
    end
    chk_bit("sync done", 1'b0, sync_busy);
  endtask
  task automatic t_defaults();
    rd(10'h191, 8'h00, "phase0");
    rd(10'h1A0, 8'h00, "options0");
    rd(10'h230, 8'h00, "sync control");
    rd(10'h3FF, 8'h00, "unmapped");
    $display("test defaults done");
  endtask
  task automatic t_phase();
    int t, bt, p, r[3];
    logic [2:0] prev;
    logic pair_ok;
    wr(10'h190, 8'h77);
    wr(10'h193, 8'h77);
    wr(10'h196, 8'h77);
    wr(10'h194, 8'h03);
    wr(10'h197, 8'h12);
    wr(10'h232, 8'h01);
    rd(10'h197, 8'h12, "phase2 readback");
    sync_pin_n <= 1'b0;
    cyc(8);
    chk_bit("held level 0", 1'b0, pair_out[0].out_a);
    chk_bit("held level 2", 1'b1, pair_out[2].out_a);
    sync_pin_n <= 1'b1;
    t = 0;
    bt = -1;
    p = -1;
    r = '{-1, -1, -1};
    pair_ok = 1'b1;
    prev = 3'h4;
    repeat (300) begin
      cyc(1);
      if (div_tick) t++;
      if (sync_busy === 1'b0 && bt < 0) bt = t;
      for (int i = 0; i < 3; i++) begin
        if (i == 0 && pair_out[0].out_a && !prev[0] && r[0] >= 0 && p < 0)
          p = t - r[0];
        if (pair_out[i].out_a && !prev[i] && r[i] < 0) r[i] = t;
        prev[i] = pair_out[i].out_a;
        if (pair_out[i].out_a !== pair_out[i].out_b) pair_ok = 1'b0;
      end
    end
    chk_bit("sync latency", 1'b1, bt >= 14 && bt <= 17);
    chk_byte("offset ch1", 8'h03, 8'(r[1] - r[0]));
    chk_byte("offset ch2", 8'h0A, 8'(r[2] - r[0]));
    chk_byte("period ch0", 8'h10, 8'(p));
    chk_bit("pair match", 1'b1, pair_ok);
    $display("test phase done");
  endtask
  task automatic t_soft_sync();
    for (int k = 1; k < 3; k++) begin
      wr(10'h230, 8'(k));
      cyc(4);
      chk_bit("staged bit inert", 1'b0, sync_busy);
      wr(10'h232, 8'h01);
      cyc(2);
      chk_bit("applied bit syncs", 1'b1, sync_busy);
      if (k == 2) chk_bit("dist off", 1'b0, pair_out[1].on_a);
      wr(10'h230, 8'h00);
      cyc(40);
      chk_bit("held until cleared", 1'b1, sync_busy);
      rd(10'h1A3, 8'h0C, "status held");
      wr(10'h232, 8'h01);
      wait_idle();
    end
    $display("test soft sync done");
  endtask
  task automatic t_opts();
    int edges;
    logic last;
    wr(10'h1A0, 8'h01);
    wr(10'h1A1, 8'h04);
    wr(10'h232, 8'h01);
    cal_active <= 1'b1;
    cyc(4);
    edges = 0;
    last = pair_out[0].out_a;
    repeat (150) begin
      cyc(1);
      if (pair_out[0].out_a !== last) edges++;
      last = pair_out[0].out_a;
    end
    chk_bit("cal syncs", 1'b1, sync_busy);
    chk_bit("excluded runs", 1'b1, edges > 2);
    chk_bit("held a", 1'b0, pair_out[1].out_a);
    chk_bit("inverted b", 1'b1, pair_out[1].out_b);
    cal_active <= 1'b0;
    wait_idle();
    for (int m = 0; m < 4; m++) begin
      wr(10'h1A2, 8'(m << 3));
      wr(10'h232, 8'h01);
      cyc(3);
      chk_bit("safe mode", m == 2, pair_out[2].safe_a);
      if (m != 1) chk_bit("output on", m == 0, pair_out[2].on_a);
    end
    $display("test options done");
  endtask
  task automatic t_resets();
    wr(10'h191, 8'h05);
    wr(10'h000, 8'h24);
    wr(10'h191, 8'h07);
    rd(10'h191, 8'h00, "soft reset defaults");
    chk_bit("soft reset syncs", 1'b1, sync_busy);
    wr(10'h000, 8'h00);
    wait_idle();
    wr(10'h191, 8'h05);
    reset_pin_n <= 1'b0;
    rd(10'h191, 8'h00, "pin reset defaults");
    cyc(2);
    chk_bit("pin reset syncs", 1'b1, sync_busy);
    reset_pin_n <= 1'b1;
    wait_idle();
    powerdown_pin_n <= 1'b0;
    cyc(6);
    chk_bit("pin sleep safe", 1'b1, pair_out[0].safe_b);
    chk_bit("pin sleep syncs", 1'b1, sync_busy);
    powerdown_pin_n <= 1'b1;
    wait_idle();
    $display("test resets done");
  endtask
  initial begin
    reset = 1'b1;
    reset_pin_n = 1'b1;
    sync_pin_n = 1'b1;
    powerdown_pin_n = 1'b1;
    cal_active = 1'b0;
    reg_req = '0;
    cyc(20);
    reset <= 1'b0;
    cyc(1);
    chk_bit("busy after reset", 1'b1, sync_busy);
    wait_idle();
    t_defaults();
    t_phase();
    t_soft_sync();
    t_opts();
    t_resets();
    wrap_up();
  end
endmodule
bind chan_sync_ctrl chan_sync_sva chan_sync_sva_i (.clk_sys(clk_sys),
  .reset(reset), .reset_pin_n(reset_pin_n), .sync_pin_n(sync_pin_n),
  .powerdown_pin_n(powerdown_pin_n), .cal_active(cal_active),
  .div_tick(div_tick), .div_clk_lvl(div_clk_lvl),
  .osc_div_tick(osc_div_tick), .osc_div_used(osc_div_used),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .pair_out(pair_out),
  .sync_busy(sync_busy));
`default_nettype wire
